// >>> core/snrl_loader.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [RULE1] Codes 0 to 3 load the payload into one nibble of data_holding. Here a port read in the same cycle wins and the nibble is lost.
// [RULE2] Codes 4 to 7 load the payload into one nibble of port_flash_address.
// [RULE3] Code 8 loads command_code, which then starts its operation.
// [RULE4] Code 9 loads the payload into interface_mode.
// [RULE5] Codes 10 to 15 change nothing and start nothing.
// [RULE6] Command 0 writes data_holding to port address[3:0], 2 reads it.
// [RULE7] Command 9 steps a halted processor once, 7 halts, 8 restarts.
// [RULE8] Mode 0 selects four-wire pins, mode 1 three-wire tied pins.
// [RULE9] A processor port access in the same cycle goes first.
module snrl_loader
  import snrl_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // nibble loads from the serial host
  input wire snrl_nibble_t nibble_i,
  // processor port bus, shared with the processor
  input wire logic cpu_port_busy_i,
  input wire logic [15:0] port_rdata_i,
  output snrl_port_req_t port_req_o,
  // processor run control
  output logic cpu_halted_o,
  output logic cpu_step_o,
  // serial pin mode
  output logic three_wire_o,
  // register views
  output logic [15:0] data_holding_o,
  output logic [15:0] port_flash_address_o,
  output logic [3:0] command_code_o,
  output logic [3:0] interface_mode_o,
  output logic cmd_busy_o
);

  //////////////////////////////////////////////////////////////////////////
  logic load_data;
  logic load_addr;
  logic cmd_go;
  logic read_done;
  logic [3:0] pend_cmd;
  snrl_state_t state;
  snrl_state_t next_state;

  // target decode
  // [RULE1] data nibble select
  assign load_data = nibble_i.valid && (nibble_i.target <= SEL_DATA_3);
  // [RULE2] address nibble select
  assign load_addr = nibble_i.valid && (nibble_i.target >= SEL_ADDR_0)
    && (nibble_i.target <= SEL_ADDR_3);
  // [RULE3] command load starts it
  assign cmd_go = nibble_i.valid && (nibble_i.target == SEL_CMD);

  // data holding, also filled by port reads
  snrl_nibble_reg #(
    .RST_VAL(DATA_RST)
  ) u_data (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(load_data),
    .lane_i(nibble_i.target[1:0]),
    .nib_i(nibble_i.payload),
    .word_load_i(read_done),
    .word_i(port_rdata_i),
    .value_o(data_holding_o)
  );

  // port and flash address
  snrl_nibble_reg #(
    .RST_VAL(ADDR_RST)
  ) u_addr (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(load_addr),
    .lane_i(nibble_i.target[1:0]),
    .nib_i(nibble_i.payload),
    .word_load_i(1'b0),
    .word_i(16'h0000),
    .value_o(port_flash_address_o)
  );

  //////////////////////////////////////////////////////////////////////////
  // command register
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      command_code_o <= CMD_RST;
    end
    // [RULE3] command nibble load
    else if (cmd_go)
    begin
      command_code_o <= nibble_i.payload;
    end
  end

  // interface mode register
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      interface_mode_o <= MODE_RST;
    end
    // [RULE4] mode nibble load
    else if (nibble_i.valid && nibble_i.target == SEL_MODE)
    begin
      interface_mode_o <= nibble_i.payload;
    end
    // [RULE5] other codes fall through
  end

  // [RULE8] three-wire when mode is one
  assign three_wire_o = (interface_mode_o == MODE_THREE_WIRE);

  //////////////////////////////////////////////////////////////////////////
  // run control
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      cpu_halted_o <= 1'b0;
      cpu_step_o <= 1'b0;
    end
    else
    begin
      // [RULE7] one-cycle step pulse
      cpu_step_o <= cmd_go && nibble_i.payload == CMD_STEP && cpu_halted_o;
      // [RULE7] halt and start
      if (cmd_go && nibble_i.payload == CMD_HALT)
      begin
        cpu_halted_o <= 1'b1;
      end
      else if (cmd_go && nibble_i.payload == CMD_START)
      begin
        cpu_halted_o <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // port access arbiter
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
      begin
        if (cmd_go && (nibble_i.payload == CMD_PORT_WRITE
            || nibble_i.payload == CMD_PORT_READ))
        begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        // [RULE9] processor goes first
        if (!cpu_port_busy_i)
        begin
          next_state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state and latched command
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      state <= ST_IDLE;
      pend_cmd <= CMD_RST;
    end
    else
    begin
      state <= next_state;
      if (state == ST_IDLE && next_state == ST_WAIT)
      begin
        pend_cmd <= nibble_i.payload;
      end
    end
  end

  // [RULE6] port strobe once the bus is free
  always_comb
  begin
    port_req_o.wr = (state == ST_WAIT) && !cpu_port_busy_i
      && pend_cmd == CMD_PORT_WRITE;
    port_req_o.rd = (state == ST_WAIT) && !cpu_port_busy_i
      && pend_cmd == CMD_PORT_READ;
    port_req_o.sel = port_flash_address_o[PORT_SEL_LSB +: PORT_SEL_W];
    port_req_o.wdata = data_holding_o;
  end

  // [RULE6] read data captured same cycle
  assign read_done = port_req_o.rd;
  assign cmd_busy_o = (state != ST_IDLE);

endmodule

// >>> core/snrl_pkg.sv
package snrl_pkg;

  // nibble target select codes
  localparam logic [3:0] SEL_DATA_0 = 4'h0;
  localparam logic [3:0] SEL_DATA_3 = 4'h3;
  localparam logic [3:0] SEL_ADDR_0 = 4'h4;
  localparam logic [3:0] SEL_ADDR_3 = 4'h7;
  localparam logic [3:0] SEL_CMD = 4'h8;
  localparam logic [3:0] SEL_MODE = 4'h9;

  // command codes acted on here
  localparam logic [3:0] CMD_PORT_WRITE = 4'h0;
  localparam logic [3:0] CMD_PORT_READ = 4'h2;
  localparam logic [3:0] CMD_HALT = 4'h7;
  localparam logic [3:0] CMD_START = 4'h8;
  localparam logic [3:0] CMD_STEP = 4'h9;

  // interface mode codes
  localparam logic [3:0] MODE_FOUR_WIRE = 4'h0;
  localparam logic [3:0] MODE_THREE_WIRE = 4'h1;

  // reset values
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [3:0] CMD_RST = 4'hC;
  localparam logic [3:0] MODE_RST = 4'h0;

  // field positions
  localparam int PORT_SEL_LSB = 0;
  localparam int PORT_SEL_W = 4;
  localparam int NIB_W = 4;

  // one nibble load from the serial side
  typedef struct packed {
    logic valid;
    logic [3:0] target;
    logic [3:0] payload;
  } snrl_nibble_t;

  // processor port access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] sel;
    logic [15:0] wdata;
  } snrl_port_req_t;

  // port access arbiter state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b11
  } snrl_state_t;

endpackage

// >>> core/snrl_nibble_reg.sv
`timescale 1ns/10ps
// one 16-bit register loaded a nibble at a time
module snrl_nibble_reg
  import snrl_pkg::*;
#(
  parameter logic [15:0] RST_VAL = 16'h0000
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // nibble load
  input wire logic load_i,
  input wire logic [1:0] lane_i,
  input wire logic [3:0] nib_i,
  // whole word load
  input wire logic word_load_i,
  input wire logic [15:0] word_i,
  // contents
  output logic [15:0] value_o
);

  // nibble load leaves the other lanes alone
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      value_o <= RST_VAL;
    end
    else if (word_load_i)
    begin
      value_o <= word_i;
    end
    else if (load_i)
    begin
      value_o[lane_i*NIB_W +: NIB_W] <= nib_i;
    end
  end

endmodule

// >>> tb/snrl_port_model.sv
`timescale 1ns/10ps
module snrl_port_model
  import snrl_pkg::*;
(
  // clock
  input logic sys_clk_i,
  // port bus
  input snrl_port_req_t req_i,
  output logic busy_o,
  output logic [15:0] rdata_o
);
  logic [15:0] port [16];
  always @(negedge sys_clk_i) busy_o <= 1'($urandom_range(1, 0));
  always @(posedge sys_clk_i) if (req_i.wr) port[req_i.sel] <= req_i.wdata;
  // data only valid while read
  assign rdata_o = req_i.rd ? port[req_i.sel] : ~port[req_i.sel];
endmodule

// >>> tb/snrl_loader_sva.sv
`timescale 1ns/10ps
module snrl_loader_sva
  import snrl_pkg::*;
(
  // inputs
  input logic sys_clk_i,
  input logic sys_rst_i,
  input snrl_nibble_t nibble_i,
  input logic cpu_port_busy_i,
  input logic [15:0] port_rdata_i,
  // outputs
  input snrl_port_req_t port_req_o,
  input logic cpu_halted_o,
  input logic cpu_step_o,
  input logic three_wire_o,
  input logic [15:0] data_holding_o,
  input logic [15:0] port_flash_address_o,
  input logic [3:0] command_code_o,
  input logic [3:0] interface_mode_o,
  input logic cmd_busy_o
);
  // load fields
  wire ld = nibble_i.valid;
  wire [3:0] tg = nibble_i.target;
  wire [3:0] pl = nibble_i.payload;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // register loads and port moves
  property p_dat;
    ld && tg == 4'h3 && !port_req_o.rd |=> data_holding_o[15:12] == $past(pl);
  endproperty
  a_dat: assert property (p_dat) else $error("dh");
  property p_adr;
    ld && tg == 4'h7 |=> port_flash_address_o[15:12] == $past(pl);
  endproperty
  a_adr: assert property (p_adr) else $error("pa");
  property p_cmd;
    ld && tg == 4'h8 |=> command_code_o == $past(pl);
  endproperty
  a_cmd: assert property (p_cmd) else $error("cr");
  property p_mode;
    ld && tg == 4'h9 |=> interface_mode_o == $past(pl)
      && three_wire_o == ($past(pl) == 4'h1);
  endproperty
  a_mode: assert property (p_mode) else $error("im");
  property p_unused;
    ld && tg >= 4'hA && !cmd_busy_o |=> $stable(port_flash_address_o)
      && $stable(command_code_o) && $stable(interface_mode_o)
      && $stable(cpu_halted_o) && !cmd_busy_o && !cpu_step_o;
  endproperty
  a_unused: assert property (p_unused) else $error("unused");
  property p_prio;
    port_req_o.wr || port_req_o.rd |-> !cpu_port_busy_i;
  endproperty
  a_prio: assert property (p_prio) else $error("prio");
  property p_rd;
    port_req_o.rd |=> data_holding_o == $past(port_rdata_i);
  endproperty
  a_rd: assert property (p_rd) else $error("rd");
  property p_halt;
    ld && tg == 4'h8 && pl == 4'h7 |=> ##[0:1] cpu_halted_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt");
  property p_step;
    ld && tg == 4'h8 && pl == 4'h9 && cpu_halted_o |=> cpu_step_o;
  endproperty
  a_step: assert property (p_step) else $error("step");
  property p_step_src;
    cpu_step_o |-> $past(ld && tg == 4'h8 && pl == 4'h9 && cpu_halted_o);
  endproperty
  a_step_src: assert property (p_step_src) else $error("stray step");
  // main scenarios
  c_wr: cover property (port_req_o.wr);
  c_rd: cover property (port_req_o.rd);
  c_step: cover property (cpu_step_o);
endmodule
bind snrl_loader snrl_loader_sva u_sva (.*);

// >>> tb/snrl_loader_tb.sv
`timescale 1ns/10ps
`define CHK(s, e, a) begin checks_done++; if ((a) !== (e)) begin \
  $display("[ERR] %s exp %h got %h", s, e, a); n_fail++; end end
module snrl_loader_tb
  import snrl_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  snrl_nibble_t nibble_i = '0;
  logic cpu_port_busy_i, cpu_halted_o, cpu_step_o, three_wire_o, cmd_busy_o;
  logic [15:0] port_rdata_i, data_holding_o, port_flash_address_o, dh, pa, v;
  logic [3:0] command_code_o, interface_mode_o, cr, im, t;
  snrl_port_req_t port_req_o;
  int n_fail = 0, checks_done = 0, n;
  snrl_loader u_dut (.*);
  snrl_port_model u_port (.sys_clk_i(sys_clk_i), .req_i(port_req_o),
    .busy_o(cpu_port_busy_i), .rdata_o(port_rdata_i));
  initial forever #4 sys_clk_i = ~sys_clk_i;
  // compare all registers with the model
  task automatic chk();
    `CHK("dh", dh, data_holding_o)
    `CHK("pa", pa, port_flash_address_o)
    `CHK("cr", cr, command_code_o)
    `CHK("im", im, interface_mode_o)
    `CHK("tw", im == 4'h1, three_wire_o)
  endtask
  // one nibble load, back to back when repeated
  task automatic ld(input logic [3:0] tg, input logic [3:0] pl);
    @(negedge sys_clk_i);
    chk();
    nibble_i = '{1'b1, tg, pl};
    if (tg < 4'h4) dh[4*tg[1:0]+:4] = pl;
    else if (tg < 4'h8) pa[4*tg[1:0]+:4] = pl;
    else if (tg == 4'h8) cr = pl;
    else if (tg == 4'h9) im = pl;
  endtask
  task automatic idle();
    @(negedge sys_clk_i);
    nibble_i.valid = 1'b0;
    chk();
  endtask
  // issue a command and wait out the port access
  task automatic cmd(input logic [3:0] c);
    ld(4'h8, c);
    idle();
    for (n = 0; n < 60 && cmd_busy_o !== 1'b0; n++) @(negedge sys_clk_i);
    `CHK("busy", 1'b0, cmd_busy_o)
  endtask
  task close_out();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_fail++;
    close_out();
  end
  // main sequence
  initial
  begin
    void'($urandom(60));
    dh = DATA_RST;
    pa = ADDR_RST;
    cr = CMD_RST;
    im = MODE_RST;
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    repeat (200)
    begin
      t = 4'($urandom_range(15, 0));
      ld(t == 4'h8 ? 4'h9 : t, 4'($urandom));
    end
    // both pin modes set on purpose
    ld(4'h9, MODE_THREE_WIRE);
    ld(4'h9, MODE_FOUR_WIRE);
    // write a port, read it back
    v = 16'($urandom);
    for (int i = 0; i < 4; i++) ld(4'(i), v[4*i+:4]);
    cmd(CMD_PORT_WRITE);
    for (int i = 0; i < 4; i++) ld(4'(i), ~v[4*i+:4]);
    cmd(CMD_PORT_READ);
    dh = v;
    idle();
    cmd(CMD_HALT);
    idle();
    `CHK("halt", 1'b1, cpu_halted_o)
    cmd(CMD_STEP);
    n = 0;
    repeat (4)
    begin
      n += (cpu_step_o === 1'b1);
      @(negedge sys_clk_i);
    end
    `CHK("step", 1, n)
    cmd(CMD_START);
    idle();
    `CHK("run", 1'b0, cpu_halted_o)
    cmd(CMD_STEP);
    `CHK("step run", 1'b0, cpu_step_o)
    close_out();
  end
endmodule
